// ---- ceiu_pkg.sv ----
// Constants, codes and types of the exception and interrupt recording unit.
// Assumes a single core clock domain and AXI4-Lite register access.

package ceiu_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CAUSE = 8'h04;
    localparam logic [7:0] OFS_RETPC_LO = 8'h08;
    localparam logic [7:0] OFS_RETPC_HI = 8'h0c;
    localparam logic [7:0] OFS_COMPARE = 8'h10;
    localparam logic [7:0] OFS_FCSR = 8'h14;
    localparam logic [7:0] OFS_VECTOR_LO = 8'h18;
    localparam logic [7:0] OFS_VECTOR_HI = 8'h1c;

    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int ST_IE = 0;
    localparam int ST_EXL = 1;
    localparam int ST_ERL = 2;
    localparam int ST_KSU = 3;
    localparam int ST_IM = 8;
    localparam int ST_BEV = 22;
    localparam int ST_CU = 28;
    localparam logic [31:0] STATUS_RST = 32'h0040_0004;
    localparam logic [31:0] STATUS_WMASK = 32'hf040_ff1f;

    // Cause field positions
    localparam int CA_EXC = 2;
    localparam int CA_IP = 8;
    localparam int CA_CE = 28;
    localparam int CA_BD = 31;

    // Float control/status: flags 6:2, enables 11:7, cause 17:12 (E at 17)
    localparam int FC_RM = 0;
    localparam int FC_FLAG = 2;
    localparam int FC_EN = 7;
    localparam int FC_CAUSE = 12;
    localparam logic [31:0] FCSR_WMASK = 32'h0003_ffff;

    // Exception codes
    localparam logic [4:0] EXC_INT = 5'h00;
    localparam logic [4:0] EXC_CPU = 5'h0b;
    localparam logic [4:0] EXC_FPE = 5'h0f;

    // Vectors
    localparam logic [63:0] VEC_NORMAL = 64'hffff_ffff_8000_0180;
    localparam logic [63:0] VEC_BOOT = 64'hffff_ffff_bfc0_0380;

    localparam logic [2:0] KSU_KERNEL = 3'h0;
    localparam int TIMER_IP = 7;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_DECERR = 2'h3;

    // Rounding modes
    typedef enum logic [1:0]
    {
        CEIU_RND_NEAREST = 2'b00,
        CEIU_RND_ZERO = 2'b01,
        CEIU_RND_PLUS = 2'b10,
        CEIU_RND_MINUS = 2'b11
    } ceiu_rnd_t;

    // Power modes
    typedef enum logic [1:0]
    {
        CEIU_PWR_NORMAL = 2'b00,
        CEIU_PWR_DOZE = 2'b01,
        CEIU_PWR_HALT = 2'b10
    } ceiu_pwr_t;

endpackage

// ---- ceiu_top.sv ----
// Exception and interrupt recording unit with float trap decision.
// Assumes execute-stage requests are one-cycle pulses synchronous to ref_clk.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module ceiu_top
#(
    parameter bit HAS_FPU = 1'b1
)
(
    input wire logic ref_clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Execution side
    input wire logic instr_valid,
    input wire logic instr_is_cop,
    input wire logic [1:0] instr_cop_num,
    input wire logic [63:0] instr_pc,
    input wire logic in_delay_slot,
    input wire logic [63:0] branch_pc,
    input wire logic mode64,
    input wire logic timer_match,
    input wire logic [5:0] hw_interrupt_lines_n,
    input wire logic enter_doze,
    input wire logic enter_halt,
    // Float operation result
    input wire logic fp_done,
    input wire logic [5:0] fp_exc,
    input wire logic fp_sign,
    input wire logic fp_double,
    input wire logic [63:0] fp_value,
    // Outputs
    output logic exc_taken,
    output logic [63:0] exc_vector,
    output logic [1:0] power_mode,
    output logic fp_wr_en,
    output logic [63:0] fp_wr_data
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic awready;
        logic wready;
        logic have_aw;
        logic have_w;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] status;
        logic [31:0] cause;
        logic [63:0] retpc;
        logic [31:0] compare;
        logic [31:0] fcsr;
        logic exc_taken;
        logic [63:0] exc_vector;
        logic [1:0] pwr;
        logic fp_wr_en;
        logic [63:0] fp_wr_data;
    } ceiu_state_t;

    ceiu_state_t st_ff;
    ceiu_state_t nxt_st;

    // Merge bytes by strobe
    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] be, input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        return (old & ~m) | (nw & m);
    endfunction

    // Untrapped overflow value by rounding mode and sign
    function automatic logic [63:0] ovf_value(input logic [1:0] rm, input logic sgn,
        input logic dbl);
        logic [63:0] inf;
        logic [63:0] big;
        logic to_inf;
        inf = dbl ? {sgn, 11'h7ff, 52'h0} : {32'h0, sgn, 8'hff, 23'h0};
        big = dbl ? {sgn, 11'h7fe, {52{1'b1}}} : {32'h0, sgn, 8'hfe, {23{1'b1}}};
        unique case (ceiu_pkg::ceiu_rnd_t'(rm))
            ceiu_pkg::CEIU_RND_NEAREST: to_inf = 1'b1;
            ceiu_pkg::CEIU_RND_ZERO: to_inf = 1'b0;
            ceiu_pkg::CEIU_RND_PLUS: to_inf = ~sgn;
            ceiu_pkg::CEIU_RND_MINUS: to_inf = sgn;
        endcase
        return to_inf ? inf : big;
    endfunction

    logic [7:0] pending;
    logic int_req;
    logic cop_unusable;
    logic fpe_req;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic wr_fire;
    logic [4:0] fp_trap_std;
    logic fp_trap;

    // ------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------
    always_comb
    begin
        // Hardware lines are level-held by the source, never latched here
        pending = {st_ff.cause[ceiu_pkg::CA_IP + 7] | ~hw_interrupt_lines_n[5],
            ~hw_interrupt_lines_n[4:0], st_ff.cause[ceiu_pkg::CA_IP + 1 -: 2]};
        int_req = |(pending & st_ff.status[ceiu_pkg::ST_IM +: 8])
            & st_ff.status[ceiu_pkg::ST_IE]
            & ~(st_ff.status[ceiu_pkg::ST_EXL] & st_ff.status[ceiu_pkg::ST_ERL]);
        cop_unusable = 1'b0;
        if (instr_valid && instr_is_cop)
        begin
            if (instr_cop_num == 2'd0)
                cop_unusable = ~st_ff.status[ceiu_pkg::ST_CU]
                    & (st_ff.status[ceiu_pkg::ST_KSU +: 2] != 2'd0);
            else if (instr_cop_num == 2'd1 && !HAS_FPU)
                cop_unusable = 1'b1;
            else
                cop_unusable = ~st_ff.status[ceiu_pkg::ST_CU + instr_cop_num];
        end
        // Enabled IEEE cause or unimplemented op traps
        fp_trap_std = fp_exc[4:0] & st_ff.fcsr[ceiu_pkg::FC_EN +: 5];
        fp_trap = fp_done & ((|fp_trap_std) | fp_exc[5]);
        // Request drops once software clears the trapping cause
        fpe_req = |(st_ff.fcsr[ceiu_pkg::FC_CAUSE +: 6]
            & {1'b1, st_ff.fcsr[ceiu_pkg::FC_EN +: 5]});
        wr_fire = st_ff.have_aw & st_ff.have_w & ~st_ff.bvalid;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            ceiu_pkg::OFS_STATUS: rd_mux = st_ff.status;
            ceiu_pkg::OFS_CAUSE: rd_mux = {st_ff.cause[31:16], pending, st_ff.cause[7:0]};
            ceiu_pkg::OFS_RETPC_LO: rd_mux = st_ff.retpc[31:0];
            ceiu_pkg::OFS_RETPC_HI: rd_mux = st_ff.retpc[63:32];
            ceiu_pkg::OFS_COMPARE: rd_mux = st_ff.compare;
            ceiu_pkg::OFS_FCSR: rd_mux = st_ff.fcsr;
            ceiu_pkg::OFS_VECTOR_LO: rd_mux = st_ff.exc_vector[31:0];
            ceiu_pkg::OFS_VECTOR_HI: rd_mux = st_ff.exc_vector[63:32];
            default:
            begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.exc_taken = 1'b0;
        nxt_st.fp_wr_en = 1'b0;
        // Write channel capture, either order
        if (s_axi_awvalid && st_ff.awready)
        begin
            nxt_st.have_aw = 1'b1;
            nxt_st.waddr = s_axi_awaddr;
            nxt_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st_ff.wready)
        begin
            nxt_st.have_w = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
            nxt_st.wready = 1'b0;
        end
        if (wr_fire)
        begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = ceiu_pkg::AXI_OKAY;
            unique case (st_ff.waddr)
                ceiu_pkg::OFS_STATUS:
                    nxt_st.status = strb_merge(st_ff.status, st_ff.wdata, st_ff.wstrb,
                        ceiu_pkg::STATUS_WMASK);
                ceiu_pkg::OFS_CAUSE:
                    // Only the soft bits and the timer bit are writable
                    nxt_st.cause = strb_merge(st_ff.cause, st_ff.wdata, st_ff.wstrb,
                        32'h0000_8300);
                ceiu_pkg::OFS_RETPC_LO:
                    nxt_st.retpc[31:0] = strb_merge(st_ff.retpc[31:0], st_ff.wdata,
                        st_ff.wstrb, 32'hffff_ffff);
                ceiu_pkg::OFS_RETPC_HI:
                    nxt_st.retpc[63:32] = strb_merge(st_ff.retpc[63:32], st_ff.wdata,
                        st_ff.wstrb, 32'hffff_ffff);
                ceiu_pkg::OFS_COMPARE:
                begin
                    nxt_st.compare = strb_merge(st_ff.compare, st_ff.wdata, st_ff.wstrb,
                        32'hffff_ffff);
                    nxt_st.cause[ceiu_pkg::CA_IP + ceiu_pkg::TIMER_IP] = 1'b0;
                end
                ceiu_pkg::OFS_FCSR:
                    nxt_st.fcsr = strb_merge(st_ff.fcsr, st_ff.wdata, st_ff.wstrb,
                        ceiu_pkg::FCSR_WMASK);
                default:
                    nxt_st.bresp = ceiu_pkg::AXI_DECERR;
            endcase
        end
        if (st_ff.bvalid && s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
            nxt_st.have_aw = 1'b0;
            nxt_st.have_w = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
        end
        // Read channel
        if (s_axi_arvalid && st_ff.arready)
        begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd_mux;
            nxt_st.rresp = rd_hit ? ceiu_pkg::AXI_OKAY : ceiu_pkg::AXI_DECERR;
        end
        if (st_ff.rvalid && s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
        // Timer event sets after any clear, so a match is never lost
        if (timer_match)
            nxt_st.cause[ceiu_pkg::CA_IP + ceiu_pkg::TIMER_IP] = 1'b1;
        // Float result: flags and destination only when untrapped
        if (fp_done)
        begin
            nxt_st.fcsr[ceiu_pkg::FC_CAUSE +: 6] = fp_exc;
            if (!fp_trap)
            begin
                nxt_st.fcsr[ceiu_pkg::FC_FLAG +: 5] = st_ff.fcsr[ceiu_pkg::FC_FLAG +: 5]
                    | fp_exc[4:0];
                nxt_st.fp_wr_en = 1'b1;
                if (fp_exc[2])
                    nxt_st.fp_wr_data = ovf_value(st_ff.fcsr[ceiu_pkg::FC_RM +: 2], fp_sign,
                        fp_double);
                else
                    nxt_st.fp_wr_data = fp_value;
            end
        end
        // Exception entry, priority: unusable, float, interrupt
        if (cop_unusable || fpe_req || int_req)
        begin
            nxt_st.exc_taken = 1'b1;
            nxt_st.exc_vector = st_ff.status[ceiu_pkg::ST_BEV] ? ceiu_pkg::VEC_BOOT
                : ceiu_pkg::VEC_NORMAL;
            if (!mode64)
                nxt_st.exc_vector[63:32] = 32'h0;
            if (cop_unusable)
            begin
                nxt_st.cause[ceiu_pkg::CA_EXC +: 5] = ceiu_pkg::EXC_CPU;
                nxt_st.cause[ceiu_pkg::CA_CE +: 2] = instr_cop_num;
            end
            else if (fpe_req)
                nxt_st.cause[ceiu_pkg::CA_EXC +: 5] = ceiu_pkg::EXC_FPE;
            else
                nxt_st.cause[ceiu_pkg::CA_EXC +: 5] = ceiu_pkg::EXC_INT;
            if (!st_ff.status[ceiu_pkg::ST_EXL])
            begin
                nxt_st.retpc = in_delay_slot ? branch_pc : instr_pc;
                nxt_st.cause[ceiu_pkg::CA_BD] = in_delay_slot;
            end
            nxt_st.status[ceiu_pkg::ST_EXL] = 1'b1;
        end
        // Power mode
        if (int_req)
            nxt_st.pwr = 2'(ceiu_pkg::CEIU_PWR_NORMAL);
        else if (enter_halt)
            nxt_st.pwr = 2'(ceiu_pkg::CEIU_PWR_HALT);
        else if (enter_doze)
            nxt_st.pwr = 2'(ceiu_pkg::CEIU_PWR_DOZE);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff <= '0;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
            st_ff.status <= ceiu_pkg::STATUS_RST;
        end
        else
            st_ff <= nxt_st;
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign exc_taken = st_ff.exc_taken;
    assign exc_vector = st_ff.exc_vector;
    assign power_mode = st_ff.pwr;
    assign fp_wr_en = st_ff.fp_wr_en;
    assign fp_wr_data = st_ff.fp_wr_data;

endmodule

// ---- ceiu_top_asserts.sv ----
// Port-level checks of the exception unit, bound into ceiu_top.
// Assumes one clock domain; rst is asynchronous and active high.
`timescale 1ns/1ps

module ceiu_chk
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic mode64,
    input wire logic fp_done,
    input wire logic [5:0] fp_exc,
    input wire logic [63:0] fp_value,
    input wire logic exc_taken,
    input wire logic [63:0] exc_vector,
    input wire logic fp_wr_en,
    input wire logic [63:0] fp_wr_data
);
    // ------------------------------------------------------------
    // Sequences and assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Steps used by the properties below; s_ar_take and s_fp_unimpl are shared by two each
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_fp_unimpl;
        fp_done && fp_exc[5];
    endsequence
    sequence s_fp_clean;
        fp_done && fp_exc == 6'h00;
    endsequence

    a_rd_answer: assert property (s_ar_take |=> s_axi_rvalid)
        else $error("read answer missing");
    a_rd_unmapped: assert property (s_ar_take ##0 s_axi_araddr > 8'h1f |=>
        s_axi_rresp == ceiu_pkg::AXI_DECERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_rd_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_wr_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    // Upper half follows mode64 at the request edge
    a_vec_upper: assert property (exc_taken |-> exc_vector[63:32] == {32{$past(mode64)}})
        else $error("vector upper half wrong");
    a_vec_base: assert property (exc_taken |-> exc_vector[31:0] inside {32'h8000_0180, 32'hbfc0_0380})
        else $error("vector not a common vector");
    // Cause stage adds a cycle before entry
    a_unimpl_trap: assert property (s_fp_unimpl |-> ##[1:2] exc_taken)
        else $error("unimplemented op did not trap");
    a_unimpl_keep: assert property (s_fp_unimpl |=> !fp_wr_en)
        else $error("trapped op wrote a result");
    a_clean_write: assert property (s_fp_clean |=> fp_wr_en && fp_wr_data == $past(fp_value))
        else $error("clean op result not written");
    a_wr_origin: assert property (fp_wr_en |-> $past(fp_done))
        else $error("result written without an op");
endmodule

bind ceiu_top ceiu_chk u_chk
(
    .ref_clk, .rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .mode64, .fp_done, .fp_exc,
    .fp_value, .exc_taken, .exc_vector, .fp_wr_en, .fp_wr_data
);

// ---- ceiu_far_model.sv ----
// Far side: six external interrupt sources and the float result port.
// Assumes the bench calls its tasks from one process on the ref_clk grid.
`timescale 1ns/1ps

module ceiu_far_model
(
    input wire logic ref_clk,
    output logic [5:0] hw_interrupt_lines_n,
    output logic fp_done,
    output logic [5:0] fp_exc,
    output logic fp_sign,
    output logic fp_double,
    output logic [63:0] fp_value
);
    // Lines idle high; payload starts scrambled
    initial
    begin
        hw_interrupt_lines_n = 6'h3f;
        {fp_done, fp_exc, fp_sign, fp_double, fp_value} = {1'b0, 6'h3f, 2'b11, 64'h5a5a_a5a5_5a5a_a5a5};
    end
    // A source holds its line low until serviced; the core latches nothing
    task automatic line_set(input int k, input logic on);
        @(posedge ref_clk);
        hw_interrupt_lines_n[k] <= !on;
    endtask
    // One-cycle strobe; exception bits and value then inverted so stale data fails
    task automatic fp_op(input logic [5:0] e, input logic s, input logic [63:0] v);
        @(posedge ref_clk);
        {fp_done, fp_exc, fp_sign, fp_double, fp_value} <= {1'b1, e, s, 1'b1, v};
        @(posedge ref_clk);
        {fp_done, fp_exc, fp_value} <= {1'b0, ~e, ~v};
    endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench: AXI4-Lite register tasks and execute-side stimulus.
// Assumes ceiu_top with its float unit and ceiu_far_model beside it.
`timescale 1ns/1ps

module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, power_mode;
    logic [31:0] s_axi_rdata;
    logic instr_valid = 1'b0, instr_is_cop = 1'b0, in_delay_slot = 1'b0, mode64 = 1'b0;
    logic timer_match = 1'b0, enter_doze = 1'b0, enter_halt = 1'b0;
    logic [1:0] instr_cop_num = 2'h0;
    logic [63:0] instr_pc = 64'h0, branch_pc = 64'h0;
    logic [5:0] hw_interrupt_lines_n, fp_exc;
    logic fp_done, fp_sign, fp_double, exc_taken, fp_wr_en;
    logic [63:0] fp_value, exc_vector, fp_wr_data;
    int n_fail = 0;
    int comparisons = 0;

    ceiu_top u_ceiu_top
    (
        .ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr_valid, .instr_is_cop,
        .instr_cop_num, .instr_pc, .in_delay_slot, .branch_pc, .mode64, .timer_match,
        .hw_interrupt_lines_n, .enter_doze, .enter_halt, .fp_done, .fp_exc, .fp_sign,
        .fp_double, .fp_value, .exc_taken, .exc_vector, .power_mode, .fp_wr_en, .fp_wr_data
    );
    ceiu_far_model u_far
    (
        .ref_clk, .hw_interrupt_lines_n, .fp_done, .fp_exc, .fp_sign, .fp_double, .fp_value
    );

    // ------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    // Run is a few hundred cycles; wide margin
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        results();
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Each channel drops at the edge that takes it
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = ceiu_pkg::AXI_OKAY);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        @(posedge ref_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
        input logic [1:0] er = ceiu_pkg::AXI_OKAY);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk(s_axi_rresp, er);
    endtask
    // Shorthands for the two busiest registers
    task automatic wr_st(input logic [31:0] d);
        axi_wr(ceiu_pkg::OFS_STATUS, d);
    endtask
    task automatic rd_ca(output logic [31:0] d);
        axi_rd(ceiu_pkg::OFS_CAUSE, d);
    endtask
    // One cop op in execute; its branch sits four bytes back
    task automatic issue(input logic [1:0] c, input logic [63:0] pc, input logic ds);
        @(posedge ref_clk);
        {instr_valid, instr_is_cop, instr_cop_num, instr_pc, in_delay_slot} <= {2'b11, c, pc, ds};
        branch_pc <= pc - 64'h4;
        @(posedge ref_clk);
        {instr_valid, instr_is_cop} <= 2'b00;
    endtask
    // Watches n edges; keeps the vector of the first entry seen
    task automatic wait_exc(input int n, input logic exp, output logic [63:0] v);
        logic seen;
        seen = 1'b0;
        repeat (n)
        begin
            @(posedge ref_clk);
            if (!seen) v = exc_vector;
            seen = seen | (exc_taken === 1'b1);
        end
        chk(seen, exp);
    endtask
    // Let an entry in flight land first
    task automatic no_exc();
        logic [63:0] v;
        repeat (3) @(posedge ref_clk);
        wait_exc(5, 1'b0, v);
    endtask
    task automatic pulse(input logic tmr);
        @(posedge ref_clk);
        {timer_match, enter_doze} <= {tmr, !tmr};
        @(posedge ref_clk);
        {timer_match, enter_doze} <= 2'b00;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [63:0] v;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        axi_rd(ceiu_pkg::OFS_STATUS, d);
        chk(d, ceiu_pkg::STATUS_RST);
        axi_rd(8'h40, d, ceiu_pkg::AXI_DECERR);
        chk(d, 32'h0);
        axi_wr(8'h40, 32'h1, ceiu_pkg::AXI_DECERR);
        $display("test reset done");
        // User mode, no usable bits: entry, then a nested entry at level one
        wr_st(32'h10);
        issue(2'h1, 64'h0040_1000, 1'b0);
        wait_exc(2, 1'b1, v);
        chk(v, 64'h8000_0180);
        rd_ca(d);
        chk({d[31], d[29:28], d[6:2]}, {3'b001, ceiu_pkg::EXC_CPU});
        issue(2'h2, 64'h0040_2000, 1'b1);
        wait_exc(2, 1'b1, v);
        rd_ca(d);
        chk({d[31], d[29:28], d[6:2]}, {3'b010, ceiu_pkg::EXC_CPU});
        axi_rd(ceiu_pkg::OFS_RETPC_LO, d);
        chk(d, 32'h0040_1000);
        mode64 <= 1'b1;
        wr_st(32'h10);
        issue(2'h3, 64'h0040_3000, 1'b1);
        wait_exc(2, 1'b1, v);
        chk(v, ceiu_pkg::VEC_NORMAL);
        rd_ca(d);
        chk({d[31], d[29:28]}, 3'b111);
        axi_rd(ceiu_pkg::OFS_RETPC_LO, d);
        chk(d, 32'h0040_2ffc);
        mode64 <= 1'b0;
        // System coprocessor: kernel never traps, user traps; then cop 1 passes with usable bit one
        wr_st(32'h0);
        issue(2'h0, 64'h0040_4000, 1'b0);
        wait_exc(3, 1'b0, v);
        wr_st(32'h0040_0010);
        issue(2'h0, 64'h0040_5000, 1'b0);
        wait_exc(2, 1'b1, v);
        chk(v, 64'hbfc0_0380);
        wr_st(32'h2000_0010);
        issue(2'h1, 64'h0040_6000, 1'b0);
        wait_exc(3, 1'b0, v);
        $display("test unusable done");
        // Hardware line: masked, unmasked with wake, then refused two ways
        wr_st(32'h1);
        u_far.line_set(0, 1'b1);
        pulse(1'b0);
        no_exc();
        chk(power_mode, ceiu_pkg::CEIU_PWR_DOZE);
        rd_ca(d);
        chk(d[15:8], 8'h04);
        wr_st(32'h401);
        wait_exc(6, 1'b1, v);
        chk(v, 64'h8000_0180);
        chk(power_mode, ceiu_pkg::CEIU_PWR_NORMAL);
        wr_st(32'h407);
        no_exc();
        wr_st(32'h400);
        no_exc();
        u_far.line_set(0, 1'b0);
        rd_ca(d);
        chk(d[15:8], 8'h00);
        // Both software bits raise and clear
        wr_st(32'h301);
        axi_wr(ceiu_pkg::OFS_CAUSE, 32'h300);
        wait_exc(4, 1'b1, v);
        axi_wr(ceiu_pkg::OFS_CAUSE, 32'h0);
        no_exc();
        // Timer pending: cleared by a compare write, then by a zero write
        wr_st(32'h0);
        for (int i = 0; i < 2; i++)
        begin
            pulse(1'b1);
            rd_ca(d);
            chk(d[15], 1'b1);
            axi_wr(i ? ceiu_pkg::OFS_CAUSE : ceiu_pkg::OFS_COMPARE, 32'h0);
            rd_ca(d);
            chk(d[15], 1'b0);
        end
        $display("test interrupt done");
        // Float: clean, flagged, trapped, unimplemented; overflow trap enabled only
        axi_wr(ceiu_pkg::OFS_FCSR, 32'h200);
        u_far.fp_op(6'h00, 1'b0, 64'h4000_0000_0000_0000);
        u_far.fp_op(6'h01, 1'b0, 64'h3ff0_0000_0000_0001);
        #1;
        chk({fp_wr_en, fp_wr_data[62:0]}, 64'hbff0_0000_0000_0001);
        axi_rd(ceiu_pkg::OFS_FCSR, d);
        chk(d, 32'h1204);
        u_far.fp_op(6'h04, 1'b1, 64'h7000_0000_0000_0000);
        #1;
        chk(fp_wr_en, 1'b0);
        wait_exc(4, 1'b1, v);
        axi_rd(ceiu_pkg::OFS_FCSR, d);
        chk(d, 32'h4204);
        rd_ca(d);
        chk(d[6:2], ceiu_pkg::EXC_FPE);
        axi_wr(ceiu_pkg::OFS_FCSR, 32'h200);
        no_exc();
        u_far.fp_op(6'h20, 1'b0, 64'h1);
        wait_exc(4, 1'b1, v);
        axi_wr(ceiu_pkg::OFS_FCSR, 32'h0);
        no_exc();
        // Untrapped overflow over every rounding mode and both signs
        for (int m = 0; m < 8; m++)
        begin
            axi_wr(ceiu_pkg::OFS_FCSR, 32'(m >> 1));
            u_far.fp_op(6'h04, m[0], 64'h0);
            #1;
            chk(fp_wr_data, {m[0], (m < 2 || m == 4 || m == 7) ? 63'h7ff0_0000_0000_0000 : 63'h7fef_ffff_ffff_ffff});
        end
        $display("test float done");
        results();
    end
endmodule
